// *** dio_unit.sv ***
/*
  Digital input/output unit: eight sampled inputs with rising-edge
  counters, four switched outputs with voltage read-back, fault latch
  and edge acknowledge, a plain register port and one interrupt.
  Assumes an external comparator gives the read-back pins at half
  the module supply, and a controller that polls the registers.
*/
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module dio_unit
  import dio_pkg::*;
#(
  parameter int unsigned FAULT_CYCLES = FAULT_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // register port
  input  wire bus_req_t          req,
  output logic      [DATA_W-1:0] rdata,
  // input pins
  input  wire logic [N_IN-1:0]   in_pins,
  // output pins and read-back comparators
  output logic      [N_OUT-1:0]  out_pins,
  input  wire logic [N_OUT-1:0]  readback_pins,
  // status
  output logic      [N_OUT-1:0]  output_fault_flag,
  output logic                   irq
);

  if (FAULT_CYCLES < 2 || FAULT_CYCLES > (2 ** TIMER_W)) begin : g_bad
    $error("FAULT_CYCLES does not fit the fault timer");
  end

  localparam logic [TIMER_W-1:0] TRIP_AT = TIMER_W'(FAULT_CYCLES - 1);

  dio_state_t       s_reg;
  dio_state_t       s_next;
  logic [N_IN-1:0]  input_level;
  logic [N_OUT-1:0] output_voltage_seen;
  logic [N_IN-1:0]  rise;
  logic [N_OUT-1:0] ack_rise;
  logic [N_OUT-1:0] trip;
  logic             wr_cmd;
  logic             wr_ack;
  logic             wr_stat;
  logic             wr_mask;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input bus_req_t r,
                               input logic [ADDR_W-1:0] off);
    hit = (r.addr == off);
  endfunction

  function automatic logic [DATA_W-1:0] read_word(
      input logic [ADDR_W-1:0] a, input dio_state_t st);
    read_word = '0;
    // counters fill the upper half of the index space
    if ((a & OFF_COUNT_BASE) != '0) begin
      read_word = st.cnt[3'(a - OFF_COUNT_BASE)];
    end else begin
      case (a)
        OFF_INPUT_LEVEL:    read_word = {8'h00, st.level};
        OFF_OUTPUT_COMMAND: read_word = {12'h000, st.cmd};
        OFF_VOLTAGE_SEEN:   read_word = {12'h000, st.seen};
        OFF_FAULT_FLAG:     read_word = {12'h000, st.fault};
        OFF_FAULT_ACK:      read_word = {12'h000, st.ack};
        OFF_IRQ_STATUS:     read_word = {4'h0, st.status};
        OFF_IRQ_MASK:       read_word = {4'h0, st.mask};
        default:            read_word = '0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH      (N_IN)
  ) u_in_sync (
    .clk        (clk),
    .nrst       (nrst),
    .pins_async (in_pins),
    .level      (input_level)
  );

  // comparator at half supply sits outside; a high pin means voltage
  pin_sync #(
    .WIDTH      (N_OUT)
  ) u_rb_sync (
    .clk        (clk),
    .nrst       (nrst),
    .pins_async (readback_pins),
    .level      (output_voltage_seen)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next   = s_reg;
    wr_cmd   = req.wr && hit(req, OFF_OUTPUT_COMMAND);
    wr_ack   = req.wr && hit(req, OFF_FAULT_ACK);
    wr_stat  = req.wr && hit(req, OFF_IRQ_STATUS);
    wr_mask  = req.wr && hit(req, OFF_IRQ_MASK);

    s_next.level = input_level;
    rise         = input_level & ~s_reg.level;
    for (int j = 0; j < N_IN; j++) begin
      if (rise[j]) begin
        s_next.cnt[j] = s_reg.cnt[j] + 16'h0001;
      end
    end

    s_next.seen = output_voltage_seen;

    if (wr_cmd) begin
      s_next.cmd = req.wdata[N_OUT-1:0];
    end
    if (wr_ack) begin
      s_next.ack = req.wdata[N_OUT-1:0];
    end
    // edge is taken on the stored value, so a steady level never acks
    s_next.ack_prev = s_reg.ack;
    ack_rise        = s_reg.ack & ~s_reg.ack_prev;

    // timer counts consecutive cycles of a driven pin with no voltage;
    // any voltage restarts it, giving inrush a grace window
    for (int i = 0; i < N_OUT; i++) begin
      trip[i] = 1'b0;
      if (s_reg.out[i] && !s_reg.seen[i]) begin
        if (s_reg.timer[i] == TRIP_AT) begin
          trip[i]           = 1'b1;
          s_next.timer[i]   = '0;
        end else begin
          s_next.timer[i]   = s_reg.timer[i] + 27'h0000001;
        end
      end else begin
        s_next.timer[i] = '0;
      end
    end

    // a trip in the same cycle as an ack edge keeps the fault
    s_next.fault = trip | (s_reg.fault & ~ack_rise);
    // fault masks the command; stored command stays as written
    s_next.out   = s_next.cmd & ~s_next.fault;

    s_next.status = s_reg.status;
    if (wr_stat) begin
      s_next.status = s_reg.status & ~req.wdata[IRQ_W-1:0];
    end
    s_next.status[IRQ_FAULT_LSB +: N_OUT] =
      s_next.status[IRQ_FAULT_LSB +: N_OUT] | trip;
    s_next.status[IRQ_RISE_LSB +: N_IN] =
      s_next.status[IRQ_RISE_LSB +: N_IN] | rise;
    if (wr_mask) begin
      s_next.mask = req.wdata[IRQ_W-1:0];
    end

    s_next.rdata = '0;
    if (req.rd) begin
      s_next.rdata = read_word(req.addr, s_reg);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg          <= '0;
      s_reg.cmd      <= RST_COMMAND;
      s_reg.ack      <= RST_ACK;
      s_reg.ack_prev <= RST_ACK;
      s_reg.mask     <= RST_MASK;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata             = s_reg.rdata;
  assign out_pins          = s_reg.out;
  assign output_fault_flag = s_reg.fault;
  assign irq               = |(s_reg.status & s_reg.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_fault_blocks_out: assert property (
    (out_pins & output_fault_flag) == '0)
    else $error("output driven while fault latched");

  a_out_follows_cmd: assert property (
    $past(wr_cmd) && (output_fault_flag == '0)
    |-> out_pins == $past(req.wdata[N_OUT-1:0]))
    else $error("output does not follow command");

  a_read_latency: assert property (
    req.rd && hit(req, OFF_INPUT_LEVEL)
    |=> rdata == {8'h00, $past(s_reg.level)})
    else $error("input level read data wrong");

  a_irq_level: assert property (
    $past(wr_mask) && ($past(req.wdata[IRQ_W-1:0]) == '0) |-> !irq)
    else $error("interrupt high with all masked");

  // ----------------------------------------------------------------
  // register port checks
  // ----------------------------------------------------------------
  // read data stands one cycle only, so a late sample sees zero
  a_rdata_idle: assert property (
    !req.rd |=> rdata == '0)
    else $error("read data present without a read");

  a_mask_write: assert property (
    wr_mask |=> s_reg.mask == $past(req.wdata[IRQ_W-1:0]))
    else $error("mask write did not land");

  // an event in the clearing cycle wins, so only quiet cycles are tested
  a_status_clear: assert property (
    wr_stat && (trip == '0) && (rise == '0)
    |=> (s_reg.status & $past(req.wdata[IRQ_W-1:0])) == '0)
    else $error("status bits not cleared by write of one");

  a_ack_write: assert property (
    wr_ack |=> s_reg.ack == $past(req.wdata[N_OUT-1:0]))
    else $error("ack write did not land");

  a_ack_prev_holds: assert property (
    1'b1 |=> s_reg.ack_prev == $past(s_reg.ack))
    else $error("previous ack value not kept");

  a_level_reg: assert property (
    1'b1 |=> s_reg.level == $past(input_level))
    else $error("input level register lags");

  a_seen_follows: assert property (
    1'b1 |=> s_reg.seen == $past(output_voltage_seen))
    else $error("read-back flag lags");

  for (genvar j = 0; j < N_IN; j++) begin : g_in_chk
    a_rise_counts: assert property (
      rise[j] |=> s_reg.cnt[j] == 16'($past(s_reg.cnt[j]) + 16'h0001))
      else $error("rising edge not counted");
    a_count_holds: assert property (
      !rise[j] |=> $stable(s_reg.cnt[j]))
      else $error("counter moved without edge");
    a_rise_flags_irq: assert property (
      rise[j] |=> s_reg.status[IRQ_RISE_LSB + j])
      else $error("rising edge not flagged in status");
  end

  for (genvar i = 0; i < N_OUT; i++) begin : g_out_chk
    a_trip_timeout: assert property (
      $rose(output_fault_flag[i])
      |-> $past(s_reg.timer[i]) == TRIP_AT && !$past(s_reg.seen[i]))
      else $error("fault set before timeout");
    a_seen_restarts: assert property (
      s_reg.seen[i] |=> s_reg.timer[i] == '0)
      else $error("timer kept running with voltage seen");
    a_trip_flags_irq: assert property (
      trip[i] |=> s_reg.status[IRQ_FAULT_LSB + i])
      else $error("fault trip not flagged in status");
    a_off_no_timer: assert property (
      !s_reg.out[i] |=> s_reg.timer[i] == '0)
      else $error("timer ran with output off");
    a_ack_edge_clears: assert property (
      output_fault_flag[i] && ack_rise[i] && !trip[i]
      |=> !output_fault_flag[i] ##1 !output_fault_flag[i] || trip[i])
      else $error("ack edge did not clear fault");
    a_steady_ack_holds: assert property (
      output_fault_flag[i] && !ack_rise[i] |=> output_fault_flag[i])
      else $error("fault cleared without ack edge");
  end

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_fault_set: cover property ($rose(output_fault_flag[0]));
  c_fault_acked: cover property ($fell(output_fault_flag[0]));
  c_count_wrap: cover property (rise[0] && s_reg.cnt[0] == 16'hffff);
  c_irq_raised: cover property ($rose(irq));
  c_read_then_write: cover property (req.rd ##1 req.wr);

endmodule // dio_unit

// *** dio_pkg.sv ***
/*
  Shared constants and types for the digital input/output unit:
  register offsets, field positions, reset values, timing counts,
  the register bus request and the unit's state record.
  Assumes one clock at 200 MHz and a synchronous active-low reset.
*/
package dio_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_IN    = 8;
  localparam int N_OUT   = 4;
  localparam int CNT_W   = 16;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 16;
  localparam int IRQ_W   = 12;
  localparam int TIMER_W = 27;

  // ----------------------------------------------------------------
  // register offsets (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_INPUT_LEVEL    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_COMMAND = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_VOLTAGE_SEEN   = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_FAULT_FLAG     = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_FAULT_ACK      = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS     = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK       = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_COUNT_BASE     = 4'h8;

  // ----------------------------------------------------------------
  // field positions in irq status and mask
  // ----------------------------------------------------------------
  localparam int IRQ_FAULT_LSB = 0;
  localparam int IRQ_RISE_LSB  = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [N_OUT-1:0] RST_COMMAND = 4'h0;
  localparam logic [N_OUT-1:0] RST_ACK     = 4'h0;
  localparam logic [IRQ_W-1:0] RST_MASK    = 12'h000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_FREQ_HZ   = 64'd200_000_000;
  localparam longint unsigned FAULT_TIME_MS = 64'd500;
  // least time, so round up
  localparam int unsigned FAULT_CYCLES_DEF =
    int'((FAULT_TIME_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [N_IN-1:0]                level;
    logic [N_IN-1:0][CNT_W-1:0]     cnt;
    logic [N_OUT-1:0]               cmd;
    logic [N_OUT-1:0]               out;
    logic [N_OUT-1:0]               seen;
    logic [N_OUT-1:0]               fault;
    logic [N_OUT-1:0]               ack;
    logic [N_OUT-1:0]               ack_prev;
    logic [N_OUT-1:0][TIMER_W-1:0]  timer;
    logic [IRQ_W-1:0]               status;
    logic [IRQ_W-1:0]               mask;
    logic [DATA_W-1:0]              rdata;
  } dio_state_t;

endpackage

// *** pin_sync.sv ***
/*
  Three-stage synchroniser with agreement filter for pin inputs.
  Assumes pins are asynchronous to clk; output level follows a pin
  once the second and third stages agree.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // pins and filtered level
  input  wire logic [WIDTH-1:0] pins_async,
  output logic      [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;
  logic [WIDTH-1:0] agree;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.s1    = pins_async;
    s_next.s2    = s_reg.s1;
    s_next.s3    = s_reg.s2;
    // s1 is read only by s2; filter looks at s2 and s3
    agree        = ~(s_reg.s2 ^ s_reg.s3);
    s_next.level = (agree & s_reg.s3) | (~agree & s_reg.level);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.level;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_level_agrees: assert property (@(posedge clk) disable iff (!nrst)
    ((s_reg.level ^ $past(s_reg.level)) &
     ($past(s_reg.s2) ^ $past(s_reg.s3))) == '0)
    else $error("level changed without stage agreement");

endmodule // pin_sync

// *** load_model.sv ***
/*
  Output load and read-back comparator behind the four output pins.
  Assumes out_pins come from the unit and the bench sets shorted.
*/
`timescale 1ns/10ps
module load_model
  import dio_pkg::*;
#(
  parameter int RISE_CYCLES = 8
) (
  // clock
  input  wire logic             clk,
  // pins
  input  wire logic [N_OUT-1:0] out_pins,
  input  wire logic [N_OUT-1:0] shorted,
  output logic      [N_OUT-1:0] readback_pins
);
  // ----------------------------------------
  // load and comparator
  // ----------------------------------------
  int ramp [N_OUT];

  // capacitive load: voltage lags switch-on, kept below the fault time
  always_ff @(posedge clk) begin
    for (int i = 0; i < N_OUT; i++) begin
      if (!out_pins[i] || shorted[i]) begin
        ramp[i] <= 0;
      end else if (ramp[i] < RISE_CYCLES) begin
        ramp[i] <= ramp[i] + 1;
      end
      readback_pins[i] <= out_pins[i] && !shorted[i]
                          && (ramp[i] >= RISE_CYCLES);
    end
  end
endmodule // load_model

// *** digital_io_with_output_fault_latch_test.sv ***
/*
  Self-checking bench for the digital input/output unit.
  Assumes the unit's register map and a shortened fault time.
*/
`timescale 1ns/10ps
module digital_io_with_output_fault_latch_test;
  import dio_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int FC = 20;
  // scaled controller poll spacing; inputs are held at least this long
  localparam int POLL = 8;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  bus_req_t          req = '0;
  logic [DATA_W-1:0] rdata;
  logic [N_IN-1:0]   in_pins = '0;
  logic [N_OUT-1:0]  out_pins;
  logic [N_OUT-1:0]  readback_pins;
  logic [N_OUT-1:0]  output_fault_flag;
  logic [N_OUT-1:0]  shorted = '0;
  logic              irq;
  int                miscompares = 0;
  int                checks = 0;

  always #2.5 clk = ~clk;

  dio_unit #(.FAULT_CYCLES(FC)) dut (
    .clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
    .in_pins(in_pins), .out_pins(out_pins),
    .readback_pins(readback_pins),
    .output_fault_flag(output_fault_flag), .irq(irq));

  load_model load (.clk(clk), .out_pins(out_pins), .shorted(shorted),
    .readback_pins(readback_pins));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic drive_pins(input logic [N_IN-1:0] v);
    @(posedge clk);
    in_pins <= v;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    chk(what, exp, rdata);
  endtask

  // bounded wait; an exhausted bound ends the run
  task automatic wait_flag(input int ch, input logic v, output int n);
    n = 0;
    while (output_fault_flag[ch] !== v) begin
      idle(1);
      n++;
      if (n > 200) begin
        miscompares++;
        $display("mismatch fault wait expected %h seen %h", v, ~v);
        close_out();
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    bus_wr(4'h7, 16'hffff);
    for (int a = 0; a < 16; a++) begin
      rd_chk("reg", a[3:0], 16'h0000);
    end
    chk("pins", 16'h0000, {out_pins, output_fault_flag, 7'h00, irq});
    $display("test reset done");
  endtask

  task automatic t_inputs();
    drive_pins(8'ha5);
    idle(POLL);
    rd_chk("level", OFF_INPUT_LEVEL, 16'h00a5);
    repeat (3) begin
      drive_pins(8'hff);
      idle(POLL);
      drive_pins(8'h00);
      idle(POLL);
    end
    for (int i = 0; i < N_IN; i++) begin
      rd_chk("count", OFF_COUNT_BASE + 4'(i), 16'h0003);
    end
    rd_chk("status", OFF_IRQ_STATUS, 16'h0ff0);
    bus_wr(OFF_IRQ_MASK, 16'h0010);
    bus_wr(OFF_IRQ_STATUS, 16'h0fff);
    idle(2);
    chk("irq", 16'h0000, {15'h0, irq});
    drive_pins(8'h01);
    idle(POLL);
    chk("irq", 16'h0001, {15'h0, irq});
    bus_wr(OFF_IRQ_MASK, 16'h0000);
    idle(2);
    chk("irq", 16'h0000, {15'h0, irq});
    bus_wr(OFF_IRQ_MASK, 16'h0010);
    idle(2);
    chk("irq", 16'h0001, {15'h0, irq});
    bus_wr(OFF_IRQ_STATUS, 16'h0010);
    idle(2);
    chk("irq", 16'h0000, {15'h0, irq});
    rd_chk("mask", OFF_IRQ_MASK, 16'h0010);
    rd_chk("count", OFF_COUNT_BASE, 16'h0004);
    $display("test inputs done");
  endtask

  task automatic t_out_ok();
    bus_wr(OFF_OUTPUT_COMMAND, 16'h000f);
    idle(3 * FC);
    chk("out", 16'h000f, {12'h0, out_pins});
    chk("fault", 16'h0000, {12'h0, output_fault_flag});
    rd_chk("seen", OFF_VOLTAGE_SEEN, 16'h000f);
    rd_chk("cmd", OFF_OUTPUT_COMMAND, 16'h000f);
    bus_wr(OFF_OUTPUT_COMMAND, 16'h0005);
    idle(10);
    chk("out", 16'h0005, {12'h0, out_pins});
    rd_chk("seen", OFF_VOLTAGE_SEEN, 16'h0005);
    $display("test outputs done");
  endtask

  task automatic t_fault();
    int n;
    shorted <= 4'h1;
    bus_wr(OFF_IRQ_MASK, 16'h0001);
    wait_flag(0, 1'b1, n);
    chk("trip", 16'h0001, {15'h0, (n >= FC) && (n <= FC + 12)});
    chk("out", 16'h0004, {12'h0, out_pins});
    rd_chk("flag", OFF_FAULT_FLAG, 16'h0001);
    bus_wr(OFF_OUTPUT_COMMAND, 16'h0005);
    idle(4);
    chk("out", 16'h0004, {12'h0, out_pins});
    chk("irq", 16'h0001, {15'h0, irq});
    bus_wr(OFF_IRQ_STATUS, 16'h0001);
    idle(2);
    chk("irq", 16'h0000, {15'h0, irq});
    // controller spacing between ack changes
    idle(FC);
    bus_wr(OFF_FAULT_ACK, 16'h0001);
    #1;
    chk("flag", 16'h0001, {12'h0, output_fault_flag});
    idle(1);
    chk("flag", 16'h0000, {12'h0, output_fault_flag});
    chk("out", 16'h0005, {12'h0, out_pins});
    wait_flag(0, 1'b1, n);
    idle(FC);
    bus_wr(OFF_FAULT_ACK, 16'h0001);
    idle(FC);
    chk("flag", 16'h0001, {12'h0, output_fault_flag});
    bus_wr(OFF_FAULT_ACK, 16'h0000);
    idle(FC);
    chk("flag", 16'h0001, {12'h0, output_fault_flag});
    shorted <= 4'h0;
    bus_wr(OFF_FAULT_ACK, 16'h0001);
    idle(3 * FC);
    chk("flag", 16'h0000, {12'h0, output_fault_flag});
    chk("out", 16'h0005, {12'h0, out_pins});
    rd_chk("ack", OFF_FAULT_ACK, 16'h0001);
    $display("test fault done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    idle(2);
    t_reset();
    t_inputs();
    t_out_ok();
    t_fault();
    close_out();
  end
endmodule // digital_io_with_output_fault_latch_test
